// [rtl/i2cm_pkg.sv]
package i2cm_pkg;
  // register word offsets (byte addresses)
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] BUF_OFS  = 4'h8;
  localparam logic [3:0] RATE_OFS = 4'hc;
  // control_reg_two fields
  localparam int CTRL_START   = 0;
  localparam int CTRL_IE      = 1;
  localparam int CTRL_STOP    = 2;
  localparam int CTRL_RECEIVE_START_BIT    = 3;
  localparam int CTRL_ACKSEQ  = 4;
  localparam int CTRL_ACKVAL  = 5;
  localparam int CTRL_ACK_STATUS_BIT = 6;
  localparam int CTRL_EN      = 7;
  // port_status_reg fields
  localparam int STAT_BF    = 0;
  localparam int STAT_OV    = 1;
  localparam int STAT_WRITE_COLLISION_FLAG  = 2;
  localparam int STAT_START = 3;
  localparam int STAT_STOP  = 4;
  localparam int STAT_EVENT = 5;
  localparam int STAT_BCOL  = 6;
  // rate generator and bit counter limits
  localparam int          RATE_W     = 7;
  localparam logic [6:0]  RATE_RESET = 7'h18;
  localparam logic [3:0]  LAST_DATA  = 4'h7;
  localparam logic [3:0]  ACK_SLOT   = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_TX_LOW   = 4'h1,
    ST_TX_HIGH  = 4'h2,
    ST_RX_LOW   = 4'h3,
    ST_RX_HIGH  = 4'h4,
    ST_ACK_LOW  = 4'h5,
    ST_ACK_HIGH = 4'h6,
    ST_STOP_A   = 4'h7,
    ST_STOP_B   = 4'h8,
    ST_STOP_C   = 4'h9
  } i2cm_state_type;

  typedef struct packed {
    logic [3:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
  } i2cm_wb_req_type;
endpackage : i2cm_pkg

// [rtl/i2cm_master.sv]
`timescale 1ns/1ps
module i2cm_master (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire i2cm_pkg::i2cm_wb_req_type wb_req_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  output logic                          scl_o,
  output logic                          scl_oe_n_o,
  output logic                          sda_o,
  output logic                          sda_oe_n_o,
  output logic                          port_irq_o
);
  import i2cm_pkg::*;

  i2cm_state_type    state_reg;
  logic [1:0]        scl_sync_reg, sda_sync_reg;
  logic              sda_prev_reg;
  logic [RATE_W-1:0] rate_reg, cnt_reg;
  logic [3:0]        bit_cnt_reg;
  logic [7:0]        shift_reg, buf_reg;
  logic              en_reg, ie_reg, ackval_reg, ack_status_bit_reg;
  logic              receive_start_bit_reg, ackseq_reg, stop_reg;
  logic              bf_reg, ov_reg, write_collision_flag_reg, event_reg, bcol_reg;
  logic              start_seen_reg, stop_seen_reg;
  logic              scl_oe_n_reg, sda_oe_n_reg, irq_reg, ack_reg, scl_o_reg, sda_o_reg;
  logic [31:0]       dat_reg;
  logic              scl_s, sda_s, hold, tick, coll, idle_ok;
  logic              acc, wr, rd, wr_ctrl, wr_stat, wr_buf, wr_rate, rd_buf;
  logic              buf_take, rx_done, tx8_done, tx9_done, ack_done, stop_done;
  logic              start_det, stop_det;
  logic [3:0]        ofs;

  // second stage only; first stage feeds nothing else
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      sda_prev_reg <= 1'b1;
    end else if (ce_i) begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      sda_prev_reg <= sda_sync_reg[1];
    end
  end
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];

  // bus line conditions, seen from any master
  assign start_det = scl_s & sda_prev_reg & ~sda_s;
  assign stop_det  = scl_s & ~sda_prev_reg & sda_s;

  // wishbone decode: answer one cycle after the strobe
  assign acc     = wb_cyc_i & wb_stb_i & ~ack_reg & ce_i;
  assign ofs     = {wb_req_i.adr[3:2], 2'h0};
  assign wr      = acc & wb_req_i.we & wb_req_i.sel[0];
  assign rd      = acc & ~wb_req_i.we;
  assign wr_ctrl = wr & (ofs == CTRL_OFS);
  assign wr_stat = wr & (ofs == STAT_OFS);
  assign wr_buf  = wr & (ofs == BUF_OFS);
  assign wr_rate = wr & (ofs == RATE_OFS);
  assign rd_buf  = rd & (ofs == BUF_OFS);

  // no queueing: commands only land while nothing runs or is pending
  assign idle_ok  = en_reg & (state_reg == ST_IDLE) & ~receive_start_bit_reg & ~ackseq_reg & ~stop_reg;
  assign buf_take = wr_buf & idle_ok;

  // generator pauses while a released SCL is still low (stretching)
  always_comb begin
    case (state_reg)
      ST_TX_HIGH, ST_RX_HIGH, ST_ACK_HIGH, ST_STOP_B: hold = ~scl_s;
      ST_STOP_A: hold = sda_s;
      ST_STOP_C: hold = ~sda_s;
      default:   hold = 1'b0;
    endcase
  end
  assign tick = ce_i & (state_reg != ST_IDLE) & ~hold & (cnt_reg == '0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= RATE_RESET;
    end else if (ce_i) begin
      if (state_reg == ST_IDLE || hold || cnt_reg == '0) begin
        cnt_reg <= rate_reg;
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // released SDA seen low while SCL high, or SCL low after the stop, means another master won
  always_comb begin
    case (state_reg)
      ST_TX_HIGH:  coll = scl_s & ~sda_s & sda_oe_n_reg & (bit_cnt_reg != ACK_SLOT);
      ST_ACK_HIGH: coll = scl_s & ~sda_s & ackval_reg;
      ST_STOP_C:   coll = ~scl_s;
      default:     coll = 1'b0;
    endcase
    coll = coll & ce_i;
  end

  assign rx_done   = tick & (state_reg == ST_RX_HIGH) & (bit_cnt_reg == LAST_DATA);
  assign tx8_done  = tick & ~coll & (state_reg == ST_TX_HIGH) & (bit_cnt_reg == LAST_DATA);
  assign tx9_done  = tick & ~coll & (state_reg == ST_TX_HIGH) & (bit_cnt_reg == ACK_SLOT);
  assign ack_done  = tick & ~coll & (state_reg == ST_ACK_HIGH);
  assign stop_done = tick & ~coll & (state_reg == ST_STOP_C);

  // sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      ack_status_bit_reg  <= 1'b0;
    end else if (ce_i) begin
      if (!en_reg || coll) begin
        state_reg    <= ST_IDLE;
        scl_oe_n_reg <= 1'b1;
        sda_oe_n_reg <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            bit_cnt_reg <= 4'h0;
            if (buf_take) begin
              shift_reg    <= wb_req_i.dat[7:0];
              scl_oe_n_reg <= 1'b0;
              sda_oe_n_reg <= wb_req_i.dat[7];
              state_reg    <= ST_TX_LOW;
            end else if (receive_start_bit_reg) begin
              scl_oe_n_reg <= 1'b0;
              sda_oe_n_reg <= 1'b1;
              state_reg    <= ST_RX_LOW;
            end else if (ackseq_reg) begin
              scl_oe_n_reg <= 1'b0;
              sda_oe_n_reg <= ackval_reg;
              state_reg    <= ST_ACK_LOW;
            end else if (stop_reg) begin
              scl_oe_n_reg <= 1'b0;
              sda_oe_n_reg <= 1'b0;
              state_reg    <= ST_STOP_A;
            end
          end
          ST_TX_LOW: if (tick) begin
            scl_oe_n_reg <= 1'b1;
            state_reg    <= ST_TX_HIGH;
          end
          ST_TX_HIGH: if (tick) begin
            scl_oe_n_reg <= 1'b0;
            if (bit_cnt_reg == ACK_SLOT) begin
              ack_status_bit_reg <= sda_s;
              state_reg   <= ST_IDLE;
            end else begin
              bit_cnt_reg  <= bit_cnt_reg + 1'b1;
              shift_reg    <= {shift_reg[6:0], 1'b0};
              sda_oe_n_reg <= (bit_cnt_reg == LAST_DATA) ? 1'b1 : shift_reg[6];
              state_reg    <= ST_TX_LOW;
            end
          end
          ST_RX_LOW: if (tick) begin
            scl_oe_n_reg <= 1'b1;
            state_reg    <= ST_RX_HIGH;
          end
          ST_RX_HIGH: if (tick) begin
            scl_oe_n_reg <= 1'b0;
            shift_reg    <= {shift_reg[6:0], sda_s};
            bit_cnt_reg  <= bit_cnt_reg + 1'b1;
            state_reg    <= (bit_cnt_reg == LAST_DATA) ? ST_IDLE : ST_RX_LOW;
          end
          ST_ACK_LOW: if (tick) begin
            scl_oe_n_reg <= 1'b1;
            state_reg    <= ST_ACK_HIGH;
          end
          ST_ACK_HIGH: if (tick) begin
            scl_oe_n_reg <= 1'b0;
            state_reg    <= ST_IDLE;
          end
          ST_STOP_A: if (tick) begin
            scl_oe_n_reg <= 1'b1;
            state_reg    <= ST_STOP_B;
          end
          ST_STOP_B: if (tick) begin
            sda_oe_n_reg <= 1'b1;
            state_reg    <= ST_STOP_C;
          end
          ST_STOP_C: if (tick) begin
            state_reg <= ST_IDLE;
          end
          default: begin
            state_reg    <= ST_IDLE;
            scl_oe_n_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
          end
        endcase
      end
    end
  end

  // control bits; sequence bits clear by hardware on finish or collision
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_reg     <= 1'b0;
      ie_reg     <= 1'b0;
      ackval_reg <= 1'b0;
      receive_start_bit_reg   <= 1'b0;
      ackseq_reg <= 1'b0;
      stop_reg   <= 1'b0;
      rate_reg   <= RATE_RESET;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        en_reg     <= wb_req_i.dat[CTRL_EN];
        ie_reg     <= wb_req_i.dat[CTRL_IE];
        ackval_reg <= wb_req_i.dat[CTRL_ACKVAL];
      end
      if (wr_rate) begin
        rate_reg <= wb_req_i.dat[RATE_W-1:0];
      end
      if (!en_reg || coll) begin
        receive_start_bit_reg   <= 1'b0;
        ackseq_reg <= 1'b0;
        stop_reg   <= 1'b0;
      end else if (wr_ctrl && idle_ok && !wr_buf) begin
        receive_start_bit_reg   <= wb_req_i.dat[CTRL_RECEIVE_START_BIT];
        ackseq_reg <= wb_req_i.dat[CTRL_ACKSEQ];
        stop_reg   <= wb_req_i.dat[CTRL_STOP];
      end else begin
        if (rx_done) begin
          receive_start_bit_reg <= 1'b0;
        end
        if (ack_done) begin
          ackseq_reg <= 1'b0;
        end
        if (stop_done) begin
          stop_reg <= 1'b0;
        end
      end
    end
  end

  // sticky flags: a hardware set wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bf_reg    <= 1'b0;
      ov_reg    <= 1'b0;
      write_collision_flag_reg  <= 1'b0;
      event_reg <= 1'b0;
      bcol_reg  <= 1'b0;
      buf_reg   <= 8'h00;
    end else if (ce_i) begin
      bf_reg <= (bf_reg & ~rd_buf & ~tx8_done & ~(coll & (state_reg == ST_TX_HIGH)))
                | rx_done | buf_take;
      ov_reg <= (ov_reg & ~(wr_stat & wb_req_i.dat[STAT_OV]))
                | (rx_done & bf_reg);
      write_collision_flag_reg <= (write_collision_flag_reg & ~(wr_stat & wb_req_i.dat[STAT_WRITE_COLLISION_FLAG]))
                  | (wr_buf & ~idle_ok);
      event_reg <= (event_reg & ~(wr_stat & wb_req_i.dat[STAT_EVENT]))
                   | rx_done | tx9_done | ack_done | stop_done
                   | (stop_det & en_reg);
      bcol_reg <= (bcol_reg & ~(wr_stat & wb_req_i.dat[STAT_BCOL])) | coll;
      if (rx_done) begin
        buf_reg <= {shift_reg[6:0], sda_s};
      end else if (buf_take) begin
        buf_reg <= wb_req_i.dat[7:0];
      end
    end
  end

  // bus state, kept even after a lost arbitration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg  <= 1'b0;
    end else if (ce_i) begin
      if (!en_reg) begin
        start_seen_reg <= 1'b0;
        stop_seen_reg  <= 1'b0;
      end else if (start_det) begin
        start_seen_reg <= 1'b1;
        stop_seen_reg  <= 1'b0;
      end else if (stop_det) begin
        start_seen_reg <= 1'b0;
        stop_seen_reg  <= 1'b1;
      end
    end
  end

  // bus answer and registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= acc;
      irq_reg <= event_reg & ie_reg;
      if (rd) begin
        case (ofs)
          CTRL_OFS: dat_reg <= {24'h0, en_reg, ack_status_bit_reg, ackval_reg, ackseq_reg,
                                receive_start_bit_reg, stop_reg, ie_reg, 1'b0};
          STAT_OFS: dat_reg <= {25'h0, bcol_reg, event_reg, stop_seen_reg,
                                start_seen_reg, write_collision_flag_reg, ov_reg, bf_reg};
          BUF_OFS:  dat_reg <= {24'h0, buf_reg};
          RATE_OFS: dat_reg <= {25'h0, rate_reg};
          default:  dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o   = ack_reg;
  assign wb_dat_o   = dat_reg;
  assign scl_oe_n_o = scl_oe_n_reg;
  assign sda_oe_n_o = sda_oe_n_reg;
  assign port_irq_o = irq_reg;
  // output data stays low: lines are only pulled or released
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_o_reg <= 1'b0;
      sda_o_reg <= 1'b0;
    end else if (ce_i) begin
      scl_o_reg <= 1'b0;
      sda_o_reg <= 1'b0;
    end
  end
  assign scl_o = scl_o_reg;
  assign sda_o = sda_o_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  rx_done_a: assert property (rx_done |=> bf_reg && !receive_start_bit_reg && state_reg == ST_IDLE
                                 && !scl_oe_n_reg && event_reg)
    else $error("receive completion effects missing");
  receive_start_bit_idle_a: assert property ($rose(receive_start_bit_reg) |-> $past(state_reg) == ST_IDLE)
    else $error("receive started while busy");
  write_collision_flag_keep_a: assert property (wr_buf && !idle_ok |=> write_collision_flag_reg && $stable(buf_reg))
    else $error("busy buffer write not flagged");
  ack_stat_a: assert property (tx9_done |=> ack_status_bit_reg == $past(sda_s))
    else $error("ack status wrong");
  coll_release_a: assert property ($rose(bcol_reg) |-> state_reg == ST_IDLE
                                      && scl_oe_n_reg && sda_oe_n_reg)
    else $error("collision did not release lines");
  flags_off_a: assert property (ce_i && !en_reg |=> !start_seen_reg && !stop_seen_reg)
    else $error("bus flags kept while disabled");
  bf_read_a: assert property (rd_buf && !rx_done && !buf_take |=> !bf_reg)
    else $error("buffer full not cleared by read");
  ovf_set_a: assert property (rx_done && bf_reg |=> ov_reg)
    else $error("overflow not set");
  ack_drive_a: assert property (ack_done |=> !ackseq_reg && !scl_oe_n_reg
                                   && state_reg == ST_IDLE)
    else $error("ack sequence end wrong");
  open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("line driven high");

  rx_byte_c: cover property (rx_done);
  ack_seq_c: cover property (ack_done);
  stop_seq_c: cover property (stop_done);
  bus_coll_c: cover property (coll);
endmodule : i2cm_master

// [verif/i2cm_slave_model.sv]
`timescale 1ns/1ps
module i2cm_slave_model (
  input  wire logic       clk_i,
  input  wire logic       arm_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       read_mode_i,
  input  wire logic [7:0] send_byte_i,
  input  wire logic       give_ack_i,
  input  wire logic [7:0] stretch_i,
  input  wire logic       grab_sda_i,
  output logic            scl_pull_n_o,
  output logic            sda_pull_n_o,
  output logic [7:0]      got_byte_o
);
  logic       scl_reg;
  logic       sda_reg;
  logic [3:0] rise_reg;
  logic [7:0] hold_reg;
  initial begin
    scl_reg = 1'b1;
    sda_reg = 1'b1;
    rise_reg = 4'h0;
    hold_reg = 8'h00;
    got_byte_o = 8'h00;
  end
  always @(posedge clk_i) begin
    scl_reg <= scl_i;
    if (arm_i) begin
      rise_reg <= 4'h0;
    end else if (scl_i && !scl_reg) begin
      if (rise_reg < 4'h8) got_byte_o <= {got_byte_o[6:0], sda_i};
      if (rise_reg != 4'hf) rise_reg <= rise_reg + 4'h1;
    end
  end
  // slow slave holds the clock low after each fall
  always @(posedge clk_i) begin
    if (scl_reg && !scl_i) hold_reg <= stretch_i;
    else if (hold_reg != 8'h00) hold_reg <= hold_reg - 8'h01;
  end
  // data moves only while the clock is low, so no false start or stop
  always @(posedge clk_i) begin
    if (!scl_i) begin
      if (read_mode_i) sda_reg <= (rise_reg < 4'h8) ? send_byte_i[3'h7 - rise_reg[2:0]] : 1'b1;
      else sda_reg <= !(rise_reg == 4'h8 && give_ack_i);
    end
  end
  assign scl_pull_n_o = (hold_reg == 8'h00);
  assign sda_pull_n_o = sda_reg & !grab_sda_i;
endmodule : i2cm_slave_model

// [verif/test_i2cm_master.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module test_i2cm_master;
  import i2cm_pkg::*;
  logic            clk_i, rst_i, wb_cyc, wb_stb, wb_ack, port_irq;
  i2cm_wb_req_type wb_req;
  logic [31:0]     wb_dat, rd;
  logic            scl_o, sda_o, scl_oe_n, sda_oe_n, scl_pull_n, sda_pull_n;
  logic            scl_line, sda_line, arm, read_mode, give_ack, grab_sda, sda_hi;
  logic [7:0]      send_byte, stretch, got_byte;
  int              mismatches, cmp_count, cycles;
  assign scl_line = scl_oe_n & scl_pull_n;
  assign sda_line = sda_oe_n & sda_pull_n;

  i2cm_master dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_req_i(wb_req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
    .scl_i(scl_line), .sda_i(sda_line), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .port_irq_o(port_irq));
  i2cm_slave_model slave (.clk_i(clk_i), .arm_i(arm), .scl_i(scl_line), .sda_i(sda_line),
    .read_mode_i(read_mode), .send_byte_i(send_byte), .give_ack_i(give_ack),
    .stretch_i(stretch), .grab_sda_i(grab_sda), .scl_pull_n_o(scl_pull_n),
    .sda_pull_n_o(sda_pull_n), .got_byte_o(got_byte));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task finish_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  always @(posedge clk_i) begin
    cycles++;
    if (scl_line) sda_hi <= sda_oe_n;
    if (cycles == 60000) begin
      mismatches++;
      finish_test();
    end
  end

  // waits for the answer as long as it takes; only the cycle ceiling ends a hang
  task wb_xfer(input logic [3:0] a, input logic we, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_req <= '{adr: a, dat: d, sel: 4'h1, we: we};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rd = wb_dat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_xfer

  task wr(input logic [3:0] a, input logic [31:0] d);
    wb_xfer(a, 1'b1, d);
  endtask : wr

  task rdr(input logic [3:0] a);
    wb_xfer(a, 1'b0, 32'h0);
  endtask : rdr

  // polls a register bit; the global cycle ceiling catches a hang
  task wait_bit(input logic [3:0] a, input int b, input logic v);
    do begin
      rdr(a);
    end while (rd[b] !== v);
  endtask : wait_bit

  task arm_slave(input logic rm, input logic [7:0] b, input logic ack);
    @(posedge clk_i);
    read_mode <= rm;
    send_byte <= b;
    give_ack <= ack;
    arm <= 1'b1;
    @(posedge clk_i);
    arm <= 1'b0;
  endtask : arm_slave

  initial begin
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_req = '0;
    arm = 1'b0;
    read_mode = 1'b0;
    give_ack = 1'b1;
    grab_sda = 1'b0;
    send_byte = 8'h00;
    stretch = 8'h00;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdr(CTRL_OFS);
    `CHK("ctrl reset", 32'h0, rd)
    rdr(STAT_OFS);
    `CHK("bus flags reset", 2'b00, {rd[STAT_STOP], rd[STAT_START]})
    rdr(RATE_OFS);
    `CHK("rate reset", {25'h0, RATE_RESET}, rd)
    wr(RATE_OFS, 32'h2);
    wr(CTRL_OFS, 32'h82);
    for (int a = 0; a < 2; a++) begin
      arm_slave(1'b0, 8'h00, a[0]);
      wr(BUF_OFS, 32'h5a);
      wait_bit(STAT_OFS, STAT_EVENT, 1'b1);
      rdr(CTRL_OFS);
      `CHK("ack status", !a[0], rd[CTRL_ACK_STATUS_BIT])
      `CHK("sent byte", 8'h5a, got_byte)
      wr(STAT_OFS, 32'h7e);
    end
    stretch <= 8'h14;
    arm_slave(1'b1, 8'ha5, 1'b0);
    wr(CTRL_OFS, 32'h8a);
    wr(BUF_OFS, 32'h11);
    wait_bit(STAT_OFS, STAT_BF, 1'b1);
    stretch <= 8'h00;
    `CHK("stat after rx", 4'b1001, rd[STAT_EVENT -: 4] & 4'hd)
    `CHK("clock held", 1'b0, scl_oe_n)
    `CHK("irq", 1'b1, port_irq)
    rdr(CTRL_OFS);
    `CHK("receive_start_bit cleared", 1'b0, rd[CTRL_RECEIVE_START_BIT])
    rdr(BUF_OFS);
    `CHK("rx byte", 8'ha5, rd[7:0])
    rdr(STAT_OFS);
    `CHK("full cleared", 1'b0, rd[STAT_BF])
    for (int k = 0; k < 2; k++) begin
      wr(STAT_OFS, 32'h7e);
      arm_slave(1'b1, 8'h3c, 1'b0);
      wr(CTRL_OFS, 32'h8a);
      wait_bit(STAT_OFS, STAT_EVENT, 1'b1);
    end
    `CHK("overflow", 2'b11, {rd[STAT_OV], rd[STAT_BF]})
    rdr(BUF_OFS);
    for (int v = 0; v < 2; v++) begin
      wr(STAT_OFS, 32'h7e);
      wr(CTRL_OFS, 32'h92 | (v << CTRL_ACKVAL));
      wr(CTRL_OFS, 32'h9a | (v << CTRL_ACKVAL));
      wr(BUF_OFS, 32'h22);
      wait_bit(CTRL_OFS, CTRL_ACKSEQ, 1'b0);
      `CHK("receive_start_bit refused", 1'b0, rd[CTRL_RECEIVE_START_BIT])
      `CHK("ack level", v[0], sda_hi)
      `CHK("clock low", 1'b0, scl_oe_n)
      rdr(STAT_OFS);
      `CHK("write_collision_flag in ack", 1'b1, rd[STAT_WRITE_COLLISION_FLAG])
    end
    wr(STAT_OFS, 32'h7e);
    arm_slave(1'b0, 8'h00, 1'b1);
    grab_sda <= 1'b1;
    wr(BUF_OFS, 32'hff);
    wait_bit(STAT_OFS, STAT_BCOL, 1'b1);
    `CHK("full on collision", 1'b0, rd[STAT_BF])
    `CHK("lines free", 2'b11, {scl_oe_n, sda_oe_n})
    wr(STAT_OFS, 32'h7e);
    grab_sda <= 1'b0;
    repeat (8) @(posedge clk_i);
    rdr(STAT_OFS);
    `CHK("stop watched", 2'b11, {rd[STAT_EVENT], rd[STAT_STOP]})
    wr(STAT_OFS, 32'h7e);
    arm_slave(1'b0, 8'h00, 1'b1);
    wr(BUF_OFS, 32'h81);
    wait_bit(STAT_OFS, STAT_EVENT, 1'b1);
    `CHK("restart byte", 8'h81, got_byte)
    wr(STAT_OFS, 32'h7e);
    grab_sda <= 1'b1;
    wr(CTRL_OFS, 32'hb2);
    wait_bit(STAT_OFS, STAT_BCOL, 1'b1);
    rdr(CTRL_OFS);
    `CHK("ack aborted", 1'b0, rd[CTRL_ACKSEQ])
    `CHK("lines free ack", 2'b11, {scl_oe_n, sda_oe_n})
    grab_sda <= 1'b0;
    arm_slave(1'b0, 8'h00, 1'b1);
    // the released grab makes a stop; clear its event before the next byte
    repeat (4) @(posedge clk_i);
    wr(STAT_OFS, 32'h7e);
    wr(BUF_OFS, 32'h0f);
    wait_bit(STAT_OFS, STAT_EVENT, 1'b1);
    wr(STAT_OFS, 32'h7e);
    wr(CTRL_OFS, 32'h86);
    wr(BUF_OFS, 32'h33);
    wait_bit(CTRL_OFS, CTRL_STOP, 1'b0);
    rdr(STAT_OFS);
    `CHK("stop flags", 3'b111, {rd[STAT_EVENT], rd[STAT_STOP], rd[STAT_WRITE_COLLISION_FLAG]})
    `CHK("stop lines", 4'b1100, {scl_oe_n, sda_oe_n, scl_o, sda_o})
    `CHK("stop irq", 1'b1, port_irq)
    wr(CTRL_OFS, 32'h0);
    rdr(STAT_OFS);
    `CHK("flags off", 2'b00, {rd[STAT_STOP], rd[STAT_START]})
    wr(CTRL_OFS, 32'h82);
    wr(BUF_OFS, 32'h55);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdr(CTRL_OFS);
    `CHK("ctrl after reset", 32'h0, rd)
    `CHK("aborted lines", 2'b11, {scl_oe_n, sda_oe_n})
    finish_test();
  end
endmodule : test_i2cm_master
